// *** design/target_queue_allegiance_manager.v ***
// Functional notes
// RULE1 - check status sets allegiance, sense kept
// RULE2 - reset, abort, device reset, new command clear
// RULE3 - shared sense: other initiators get busy
// RULE4 - allegiance suspends tagged work of nexus
// RULE5 - initiate recovery between status and completion
// RULE6 - only device reset, release, reset end
// RULE7 - extended allegiance: others busy, all suspended
// RULE8 - event notice: recovery after identify, tags
// RULE9 - extended allegiance on one nexus only
// RULE10 - extended: untagged from owner, tags queue-full
// RULE11 - queued commands resume after extended clears
// RULE12 - one untagged command per initiator nexus
// RULE13 - untagged without disconnect: busy if others
// RULE14 - tagged command into full queue: queue full
// RULE15 - tagged without disconnect privilege gets busy
// RULE16 - ordered and simple keep arrival order
// RULE17 - head tag runs first, newest first
// RULE18 - linked series never interrupted by head tag
// RULE19 - untagged with own tags queued: incorrect
// RULE20 - resume mode: suspend tagged, others busy
// RULE21 - abort mode: clear queue, unit attention others
// RULE22 - tagging disabled: reject message, run untagged
// RULE23 - queue depth is a build parameter
`timescale 1ns/100ps
`include "tqam_map.vh"
module target_queue_allegiance_manager #(
  parameter QDEPTH = `DEF_QDEPTH,
  parameter NI = `DEF_NINIT,
  parameter IW = `DEF_INIT_W,
  parameter TW = `DEF_TAG_W
) (
  input wire CLK,
  input wire RESET_N,
  input wire SEPARATE_SENSE,
  input wire QERR_ABORT,
  input wire TAG_DISABLE,
  input wire CMD_VALID,
  input wire [IW-1:0] CMD_INIT,
  input wire CMD_TAGGED,
  input wire [1:0] CMD_TAG_TYPE,
  input wire [TW-1:0] CMD_TAG,
  input wire CMD_DISC_OK,
  input wire STATUS_CHECK,
  input wire [IW-1:0] STATUS_INIT,
  input wire COMPLETE_SENT,
  input wire RECOV_REQ,
  input wire ASYNC_EVENT_FLAG,
  input wire EVENT_MSGS_SENT,
  input wire [IW-1:0] EVENT_INIT,
  input wire ABORT_MSG,
  input wire BDR_MSG,
  input wire RELEASE_MSG,
  input wire [IW-1:0] MSG_INIT,
  input wire EXEC_READY,
  input wire EXEC_DONE,
  output reg RESP_VALID,
  output reg [2:0] RESP_CODE,
  output reg RESP_REJECT,
  output reg [NI-1:0] CA_HOLD,
  output reg ECA_ACTIVE,
  output reg [IW-1:0] ECA_OWNER,
  output reg INIT_RECOVERY,
  output reg EXEC_VALID,
  output reg [IW-1:0] EXEC_INIT,
  output reg [TW-1:0] EXEC_TAG,
  output reg EXEC_UNTAGGED,
  output reg [$clog2(QDEPTH + 1)-1:0] QUEUE_COUNT,
  output reg [NI-1:0] UA_SET,
  output reg SUSPENDED
);
  localparam QCW = $clog2(QDEPTH + 1); // queue count width
  localparam [NI-1:0] ONE = {{(NI-1){1'b0}}, 1'b1}; // one-hot base

  reg [NI-1:0] ca_reg, ca_next; // contingent allegiance per initiator
  reg eca_reg, eca_next; // extended allegiance active
  reg [IW-1:0] owner_reg, owner_next; // nexus holding extended allegiance
  reg [NI-1:0] pend_reg, pend_next; // untagged command waiting per initiator
  reg busy_reg, busy_next; // an I/O process (or linked series) executing
  reg stat_open_reg, stat_open_next; // check status sent, completion not yet
  reg [IW-1:0] stat_init_reg, stat_init_next; // initiator of that status
  reg [2:0] rsp; // answer for the arriving command
  reg rej; // queue tag message rejected
  reg q_push, q_head, q_pop, q_flush; // queue controls
  reg recov; // issue initiate recovery now
  reg ua_fire; // abort-mode clearing event
  reg pick_unt; // dispatch an untagged command
  reg [IW-1:0] pick_init; // chosen untagged initiator
  reg [NI-1:0] allow; // untagged candidates
  reg tagged_eff; // command treated as tagged
  reg any_alg; // any allegiance held now
  integer i;

  wire q_valid; // queue head present
  wire [IW-1:0] q_init; // queue head initiator
  wire [TW-1:0] q_tag; // queue head tag
  wire [QCW-1:0] q_count; // entries queued
  wire [NI-1:0] q_present; // initiators with queued tags
  wire [NI-1:0] cmd_bit = ONE << CMD_INIT; // arriving initiator, one-hot
  wire [NI-1:0] owner_bit = ONE << owner_reg; // extended owner, one-hot
  wire q_full = (q_count == QDEPTH[QCW-1:0]); // see RULE23

  // queue storage; simple and ordered go to the tail, head tags to the front
  cmd_queue_store #(
    .DEPTH(QDEPTH),
    .IW(IW),
    .TW(TW),
    .CW(QCW),
    .NI(NI)
  ) u_store (
    .clk(CLK),
    .rst_n(RESET_N),
    .push(q_push),
    .at_head(q_head),
    .pop(q_pop),
    .flush(q_flush),
    .in_init(CMD_INIT),
    .in_tag(CMD_TAG),
    .head_valid(q_valid),
    .head_init(q_init),
    .head_tag(q_tag),
    .count(q_count),
    .init_present(q_present)
  );

  // admission of an arriving command
  always @* begin
    rsp = `RSP_ACCEPT;
    rej = CMD_TAGGED & TAG_DISABLE; // see RULE22
    tagged_eff = CMD_TAGGED & ~TAG_DISABLE; // rejected tag runs untagged, see RULE22
    q_push = 1'b0;
    q_head = 1'b0;
    if (eca_reg && owner_reg != CMD_INIT) begin
      rsp = `RSP_BUSY; // see RULE7
    end else if ((|(ca_reg & ~cmd_bit)) && (!SEPARATE_SENSE || !QERR_ABORT)) begin
      rsp = `RSP_BUSY; // see RULE3 see RULE20
    end else if (tagged_eff && eca_reg) begin
      rsp = `RSP_QFULL; // see RULE10
    end else if (tagged_eff && !CMD_DISC_OK) begin
      rsp = `RSP_BUSY; // see RULE15
    end else if (tagged_eff && q_full) begin
      rsp = `RSP_QFULL; // see RULE14
    end else if (tagged_eff) begin
      q_push = CMD_VALID;
      q_head = (CMD_TAG_TYPE == `TAG_HEAD); // see RULE17
    end else if (pend_reg[CMD_INIT]) begin
      rsp = `RSP_INCORRECT; // see RULE12
    end else if (q_present[CMD_INIT] && !ca_reg[CMD_INIT] && !eca_reg) begin
      rsp = `RSP_INCORRECT; // see RULE19
    end else if (!CMD_DISC_OK && (busy_reg || q_valid || (|pend_reg))) begin
      rsp = `RSP_BUSY; // see RULE13
    end
  end

  // recovery request: timing window differs for event notices
  always @* begin
    recov = 1'b0;
    if (RECOV_REQ && !eca_reg) begin // see RULE9
      if (ASYNC_EVENT_FLAG) begin
        recov = EVENT_MSGS_SENT; // see RULE8
      end else begin
        recov = stat_open_reg; // see RULE5
      end
    end
  end

  // dispatcher: untagged first, then queue head unless suspended
  always @* begin
    pick_unt = 1'b0;
    pick_init = {IW{1'b0}};
    q_pop = 1'b0;
    any_alg = eca_reg | (|ca_reg);
    if (eca_reg) begin
      allow = pend_reg & owner_bit; // see RULE10
    end else begin
      allow = pend_reg;
    end
    for (i = NI - 1; i >= 0; i = i - 1) begin
      if (allow[i]) begin
        pick_init = i[IW-1:0];
      end
    end
    if (EXEC_READY && !busy_reg) begin // see RULE18
      if (|allow) begin
        pick_unt = 1'b1;
      end else if (q_valid && !any_alg) begin
        q_pop = 1'b1; // see RULE4 see RULE7 see RULE11 see RULE16
      end
    end
  end

  // allegiance, untagged slots, execution and status tracking
  always @* begin
    ca_next = ca_reg;
    eca_next = eca_reg;
    owner_next = owner_reg;
    pend_next = pend_reg;
    busy_next = busy_reg;
    stat_open_next = stat_open_reg;
    stat_init_next = stat_init_reg;
    // clears come first so that a set in the same cycle wins
    if (CMD_VALID) begin
      ca_next = ca_next & ~cmd_bit; // see RULE2
    end
    if (ABORT_MSG) begin
      ca_next = ca_next & ~(ONE << MSG_INIT); // see RULE2
    end
    if (RELEASE_MSG && eca_reg && MSG_INIT == owner_reg) begin
      eca_next = 1'b0; // see RULE6
      ca_next = ca_next & ~owner_bit;
    end
    if (BDR_MSG) begin
      ca_next = {NI{1'b0}}; // see RULE2 see RULE6
      eca_next = 1'b0;
      pend_next = {NI{1'b0}};
    end
    if (COMPLETE_SENT) begin
      stat_open_next = 1'b0;
    end
    if (STATUS_CHECK) begin
      ca_next = ca_next | (ONE << STATUS_INIT); // see RULE1
      stat_open_next = 1'b1;
      stat_init_next = STATUS_INIT;
    end
    if (recov) begin
      eca_next = 1'b1; // see RULE5 see RULE8
      owner_next = ASYNC_EVENT_FLAG ? EVENT_INIT : stat_init_reg;
    end
    if (EXEC_DONE) begin
      busy_next = 1'b0;
    end
    if (pick_unt) begin
      pend_next = pend_next & ~(ONE << pick_init);
    end
    if (pick_unt || q_pop) begin
      busy_next = 1'b1;
    end
    if (CMD_VALID && !tagged_eff && rsp == `RSP_ACCEPT) begin
      pend_next = pend_next | cmd_bit; // see RULE12
    end
  end

  // abort-mode clearing of allegiance flushes the queue
  always @* begin
    ua_fire = QERR_ABORT && (eca_reg || (|ca_reg)) && !eca_next && (ca_next == {NI{1'b0}});
    q_flush = ua_fire | BDR_MSG; // see RULE21
  end

  // state registers
  always @(posedge CLK) begin
    if (!RESET_N) begin
      ca_reg <= {NI{1'b0}}; // see RULE2 see RULE6
      eca_reg <= 1'b0;
      owner_reg <= {IW{1'b0}};
      pend_reg <= {NI{1'b0}};
      busy_reg <= 1'b0;
      stat_open_reg <= 1'b0;
      stat_init_reg <= {IW{1'b0}};
    end else begin
      ca_reg <= ca_next;
      eca_reg <= eca_next;
      owner_reg <= owner_next;
      pend_reg <= ua_fire ? (pend_next & owner_bit) : pend_next;
      busy_reg <= busy_next;
      stat_open_reg <= stat_open_next;
      stat_init_reg <= stat_init_next;
    end
  end

  // registered outputs
  always @(posedge CLK) begin
    if (!RESET_N) begin
      RESP_VALID <= 1'b0;
      RESP_CODE <= `RSP_ACCEPT;
      RESP_REJECT <= 1'b0;
      CA_HOLD <= {NI{1'b0}};
      ECA_ACTIVE <= 1'b0;
      ECA_OWNER <= {IW{1'b0}};
      INIT_RECOVERY <= 1'b0;
      EXEC_VALID <= 1'b0;
      EXEC_INIT <= {IW{1'b0}};
      EXEC_TAG <= {TW{1'b0}};
      EXEC_UNTAGGED <= 1'b0;
      QUEUE_COUNT <= {QCW{1'b0}};
      UA_SET <= {NI{1'b0}};
      SUSPENDED <= 1'b0;
    end else begin
      RESP_VALID <= CMD_VALID;
      RESP_CODE <= rsp;
      RESP_REJECT <= CMD_VALID & rej;
      CA_HOLD <= ca_next;
      ECA_ACTIVE <= eca_next;
      ECA_OWNER <= owner_next;
      INIT_RECOVERY <= recov;
      EXEC_VALID <= pick_unt | q_pop;
      EXEC_INIT <= pick_unt ? pick_init : q_init;
      EXEC_TAG <= pick_unt ? {TW{1'b0}} : q_tag;
      EXEC_UNTAGGED <= pick_unt;
      QUEUE_COUNT <= q_count;
      // others than the allegiance holders learn of the cleared queue
      UA_SET <= ua_fire ? ~(ca_reg | (eca_reg ? owner_bit : {NI{1'b0}})) : {NI{1'b0}}; // see RULE21
      SUSPENDED <= q_valid & (eca_reg | (|ca_reg)); // see RULE20
    end
  end
endmodule // target_queue_allegiance_manager

// *** shared/tqam_map.vh ***
`ifndef TQAM_MAP_VH
`define TQAM_MAP_VH
// answer codes returned for an arriving command
`define RSP_ACCEPT 3'h0
`define RSP_BUSY 3'h1
`define RSP_QFULL 3'h2
`define RSP_INCORRECT 3'h3
// queue tag kinds
`define TAG_SIMPLE 2'h0
`define TAG_HEAD 2'h1
`define TAG_ORDERED 2'h2
// default sizes
`define DEF_QDEPTH 16
`define DEF_NINIT 8
`define DEF_INIT_W 3
`define DEF_TAG_W 8
`endif

// *** design/cmd_queue_store.v ***
`timescale 1ns/100ps
`include "tqam_map.vh"
// command queue storage: tail insert, head insert, head pop, flush
module cmd_queue_store #(
  parameter DEPTH = `DEF_QDEPTH,
  parameter IW = `DEF_INIT_W,
  parameter TW = `DEF_TAG_W,
  parameter CW = 5,
  parameter NI = `DEF_NINIT
) (
  input wire clk,
  input wire rst_n,
  input wire push,
  input wire at_head,
  input wire pop,
  input wire flush,
  input wire [IW-1:0] in_init,
  input wire [TW-1:0] in_tag,
  output reg head_valid,
  output reg [IW-1:0] head_init,
  output reg [TW-1:0] head_tag,
  output reg [CW-1:0] count,
  output reg [NI-1:0] init_present
);
  reg [IW-1:0] q_init [0:DEPTH-1]; // stored initiator ids
  reg [TW-1:0] q_tag [0:DEPTH-1]; // stored queue tags
  reg [IW-1:0] a_init [0:DEPTH-1]; // after pop
  reg [TW-1:0] a_tag [0:DEPTH-1];
  reg [IW-1:0] n_init [0:DEPTH-1]; // after pop and push
  reg [TW-1:0] n_tag [0:DEPTH-1];
  reg [CW-1:0] cnt_pop; // count after pop
  reg [CW-1:0] cnt_next; // count after push
  integer i, j, k; // one loop index per process, so no index has two drivers

  // next contents: pop shifts down, head insert shifts up
  always @* begin
    cnt_pop = count - {{(CW-1){1'b0}}, pop};
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (pop && i < DEPTH - 1) begin
        a_init[i] = q_init[i+1];
        a_tag[i] = q_tag[i+1];
      end else begin
        a_init[i] = q_init[i];
        a_tag[i] = q_tag[i];
      end
    end
    for (i = 0; i < DEPTH; i = i + 1) begin
      n_init[i] = a_init[i];
      n_tag[i] = a_tag[i];
      if (push && at_head) begin
        // newest head entry goes in front: last in, first out
        if (i == 0) begin
          n_init[i] = in_init;
          n_tag[i] = in_tag;
        end else begin
          n_init[i] = a_init[i-1];
          n_tag[i] = a_tag[i-1];
        end
      end else if (push && i == cnt_pop) begin
        n_init[i] = in_init;
        n_tag[i] = in_tag;
      end
    end
    cnt_next = cnt_pop + {{(CW-1){1'b0}}, push};
  end

  // which initiators have tagged work waiting
  always @* begin
    init_present = {NI{1'b0}};
    for (j = 0; j < DEPTH; j = j + 1) begin
      if (j < count) begin
        init_present[q_init[j]] = 1'b1;
      end
    end
  end

  // storage array, no reset needed for data
  always @(posedge clk) begin
    for (k = 0; k < DEPTH; k = k + 1) begin
      q_init[k] <= n_init[k];
      q_tag[k] <= n_tag[k];
    end
  end

  // count and registered head view
  always @(posedge clk) begin
    if (!rst_n || flush) begin
      count <= {CW{1'b0}};
      head_valid <= 1'b0;
      head_init <= {IW{1'b0}};
      head_tag <= {TW{1'b0}};
    end else begin
      count <= cnt_next;
      head_valid <= (cnt_next != {CW{1'b0}});
      head_init <= n_init[0];
      head_tag <= n_tag[0];
    end
  end
endmodule // cmd_queue_store

// *** testbench/tqam_monitor.sv ***
`timescale 1ns/100ps
`include "tqam_map.vh"
// watches the answer, allegiance and dispatch ports of the manager
module tqam_monitor #(
  parameter NI = 8,
  parameter IW = 3
) (
  input wire CLK,
  input wire RESET_N,
  input wire TAG_DISABLE,
  input wire CMD_VALID,
  input wire [IW-1:0] CMD_INIT,
  input wire CMD_TAGGED,
  input wire CMD_DISC_OK,
  input wire STATUS_CHECK,
  input wire [IW-1:0] STATUS_INIT,
  input wire BDR_MSG,
  input wire RELEASE_MSG,
  input wire [IW-1:0] MSG_INIT,
  input wire RESP_VALID,
  input wire [2:0] RESP_CODE,
  input wire RESP_REJECT,
  input wire [NI-1:0] CA_HOLD,
  input wire ECA_ACTIVE,
  input wire [IW-1:0] ECA_OWNER,
  input wire INIT_RECOVERY,
  input wire EXEC_VALID,
  input wire [IW-1:0] EXEC_INIT,
  input wire EXEC_UNTAGGED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // every command is answered one cycle later, and only then
  a_resp_timing: assert property (CMD_VALID |=> RESP_VALID) else $error("no answer");
  a_resp_cause: assert property (RESP_VALID |-> $past(CMD_VALID)) else $error("stray answer");
  a_ca_enter: assert property (STATUS_CHECK |=> CA_HOLD[$past(STATUS_INIT)])
    else $error("allegiance not set");
  a_eca_keep: assert property (ECA_ACTIVE && !BDR_MSG &&
    !(RELEASE_MSG && MSG_INIT == ECA_OWNER) |=> ECA_ACTIVE) else $error("eca dropped");
  a_eca_busy: assert property (ECA_ACTIVE && CMD_VALID && CMD_INIT != ECA_OWNER
    |=> RESP_CODE == `RSP_BUSY) else $error("other not busy");
  a_eca_tag_full: assert property (ECA_ACTIVE && CMD_VALID && CMD_INIT == ECA_OWNER
    && CMD_TAGGED && !TAG_DISABLE |=> RESP_CODE == `RSP_QFULL) else $error("tag not full");
  a_nodisc_busy: assert property (CMD_VALID && CMD_TAGGED && !TAG_DISABLE
    && !CMD_DISC_OK && !ECA_ACTIVE |=> RESP_CODE == `RSP_BUSY) else $error("no busy");
  a_tag_reject: assert property (CMD_VALID && CMD_TAGGED && TAG_DISABLE
    |=> RESP_REJECT && RESP_CODE != `RSP_QFULL) else $error("no reject");
  a_eca_exec_owner: assert property (ECA_ACTIVE && $past(ECA_ACTIVE)
    && $past(ECA_ACTIVE, 2) && EXEC_VALID |-> EXEC_UNTAGGED && EXEC_INIT == ECA_OWNER)
    else $error("foreign dispatch");
  a_recov_start: assert property (INIT_RECOVERY |-> ECA_ACTIVE && !$past(ECA_ACTIVE))
    else $error("recovery misplaced");
  a_owner_fixed: assert property (ECA_ACTIVE && $past(ECA_ACTIVE) |-> $stable(ECA_OWNER))
    else $error("owner moved");
endmodule // tqam_monitor
bind target_queue_allegiance_manager tqam_monitor #(.NI(NI), .IW(IW)) mon (
  .CLK(CLK), .RESET_N(RESET_N), .TAG_DISABLE(TAG_DISABLE), .CMD_VALID(CMD_VALID),
  .CMD_INIT(CMD_INIT), .CMD_TAGGED(CMD_TAGGED), .CMD_DISC_OK(CMD_DISC_OK),
  .STATUS_CHECK(STATUS_CHECK), .STATUS_INIT(STATUS_INIT), .BDR_MSG(BDR_MSG),
  .RELEASE_MSG(RELEASE_MSG), .MSG_INIT(MSG_INIT), .RESP_VALID(RESP_VALID),
  .RESP_CODE(RESP_CODE), .RESP_REJECT(RESP_REJECT), .CA_HOLD(CA_HOLD),
  .ECA_ACTIVE(ECA_ACTIVE), .ECA_OWNER(ECA_OWNER), .INIT_RECOVERY(INIT_RECOVERY),
  .EXEC_VALID(EXEC_VALID), .EXEC_INIT(EXEC_INIT), .EXEC_UNTAGGED(EXEC_UNTAGGED));

// *** testbench/exec_sink.sv ***
`timescale 1ns/100ps
// executor model: one process at a time, short or long stay
module exec_sink (
  input wire clk,
  input wire rst_n,
  input wire slow,
  input wire start,
  output reg ready,
  output reg done
);
  reg [5:0] left_reg; // cycles until the running process ends
  // done closes the whole linked series, never part of it
  always @(posedge clk) begin
    done <= 1'b0;
    if (!rst_n) begin
      ready <= 1'b0;
      left_reg <= 6'h00;
    end else if (start) begin
      ready <= 1'b0;
      left_reg <= slow ? 6'h3F : 6'h02;
    end else if (left_reg == 6'h01) begin
      done <= 1'b1;
      left_reg <= 6'h00;
    end else if (left_reg != 6'h00) begin
      left_reg <= left_reg - 6'h01;
    end else begin
      ready <= 1'b1;
    end
  end
endmodule // exec_sink

// *** testbench/target_queue_allegiance_manager_tb_top.sv ***
`timescale 1ns/100ps
`include "tqam_map.vh"
module target_queue_allegiance_manager_tb_top;
  reg CLK = 1'b0;
  reg RESET_N = 1'b0;
  reg sep = 1'b0, qab = 1'b0, tdis = 1'b0, cv = 1'b0, ctg = 1'b0, cdo = 1'b0;
  reg aflag = 1'b0, asent = 1'b0, slow = 1'b0;
  reg [2:0] ci = 3'h0, si = 3'h0, ai = 3'h0;
  reg [1:0] cty = 2'h0;
  reg [7:0] ctag = 8'h00;
  reg [5:0] evs = 6'h00; // pulses: check, recov, abort, dev reset, release, complete
  wire rv, rj, eca, ir, ev, eu, sus, erdy, edone;
  wire [2:0] rc, eo, ei;
  wire [7:0] ca, et, ua;
  wire [4:0] qc;
  reg [7:0] expq[$];
  reg [7:0] seen[$];
  integer fails = 0, samples_checked = 0;
  always #2 CLK = ~CLK;
  target_queue_allegiance_manager dut (
    .CLK(CLK), .RESET_N(RESET_N), .SEPARATE_SENSE(sep), .QERR_ABORT(qab),
    .TAG_DISABLE(tdis), .CMD_VALID(cv), .CMD_INIT(ci), .CMD_TAGGED(ctg),
    .CMD_TAG_TYPE(cty), .CMD_TAG(ctag), .CMD_DISC_OK(cdo), .STATUS_CHECK(evs[0]),
    .STATUS_INIT(si), .COMPLETE_SENT(evs[5]), .RECOV_REQ(evs[1]),
    .ASYNC_EVENT_FLAG(aflag), .EVENT_MSGS_SENT(asent), .EVENT_INIT(ai), .ABORT_MSG(evs[2]),
    .BDR_MSG(evs[3]), .RELEASE_MSG(evs[4]), .MSG_INIT(si), .EXEC_READY(erdy),
    .EXEC_DONE(edone), .RESP_VALID(rv), .RESP_CODE(rc), .RESP_REJECT(rj),
    .CA_HOLD(ca), .ECA_ACTIVE(eca), .ECA_OWNER(eo), .INIT_RECOVERY(ir),
    .EXEC_VALID(ev), .EXEC_INIT(ei), .EXEC_TAG(et), .EXEC_UNTAGGED(eu),
    .QUEUE_COUNT(qc), .UA_SET(ua), .SUSPENDED(sus));
  exec_sink sink (.clk(CLK), .rst_n(RESET_N), .slow(slow), .start(ev), .ready(erdy),
    .done(edone));
  // records dispatched tags in order
  always @(posedge CLK) begin
    if (ev === 1'b1) seen.push_back(et);
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task report_and_stop;
    begin
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e, input [79:0] nm);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("wrong value %0s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  // one command, answer checked in the cycle after it stands
  task cmd(input [2:0] i, input t, input [1:0] ty, input [7:0] g, input d, input [2:0] x);
    begin
      @(posedge CLK);
      cv <= 1'b1;
      ci <= i;
      ctg <= t;
      cty <= ty;
      ctag <= g;
      cdo <= d;
      @(posedge CLK);
      cv <= 1'b0;
      #1;
      chk(rv, 1, "resp_vld");
      chk(rc, x, "resp_code");
    end
  endtask
  // one-cycle event pulse from initiator w
  task evt(input [2:0] k, input [2:0] w);
    begin
      @(posedge CLK);
      evs <= 6'h01 << k;
      si <= w;
      @(posedge CLK);
      evs <= 6'h00;
      #1;
    end
  endtask
  initial begin
    repeat (5000) @(posedge CLK);
    fails = fails + 1;
    report_and_stop;
  end
  initial begin : main
    reg [31:0] r;
    reg [1:0] ty;
    integer k, n;
    r = 32'hA500;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    slow <= 1'b1;
    cmd(3'h0, 1'b1, `TAG_SIMPLE, 8'h11, 1'b1, `RSP_ACCEPT);
    repeat (3) @(posedge CLK);
    for (k = 0; k < 16; k = k + 1) begin
      r = lfsr(r);
      ty = (r[1:0] == 2'h3) ? `TAG_SIMPLE : r[1:0];
      cmd(r[6:4], 1'b1, ty, r[15:8], 1'b1, `RSP_ACCEPT);
      if (ty == `TAG_HEAD) expq.push_front(r[15:8]);
      else expq.push_back(r[15:8]);
    end
    @(posedge CLK);
    #1;
    chk(qc, 16, "qcount");
    cmd(r[6:4], 1'b1, `TAG_SIMPLE, 8'h77, 1'b1, `RSP_QFULL);
    cmd(r[6:4], 1'b0, `TAG_SIMPLE, 8'h00, 1'b1, `RSP_INCORRECT);
    cmd(r[6:4], 1'b1, `TAG_SIMPLE, 8'h55, 1'b0, `RSP_BUSY);
    n = 0;
    while (seen.size() < 17 && n < 1200) begin
      @(posedge CLK);
      n = n + 1;
    end
    chk(seen[0], 8'h11, "first");
    for (k = 0; k < 16; k = k + 1) chk(seen[k+1], expq[k], "order");
    slow <= 1'b0;
    evt(3'h0, 3'h2);
    chk(ca, 8'h04, "ca_hold");
    cmd(3'h3, 1'b1, `TAG_SIMPLE, 8'h21, 1'b1, `RSP_BUSY);
    cmd(3'h2, 1'b0, `TAG_SIMPLE, 8'h00, 1'b1, `RSP_ACCEPT);
    chk(ca, 8'h00, "ca_hold");
    evt(3'h0, 3'h5);
    evt(3'h2, 3'h5);
    chk(ca, 8'h00, "ca_hold");
    evt(3'h0, 3'h1);
    evt(3'h1, 3'h1);
    chk({ir, eca, eo}, 5'h19, "recovery");
    evt(3'h5, 3'h1);
    cmd(3'h4, 1'b0, `TAG_SIMPLE, 8'h00, 1'b1, `RSP_BUSY);
    cmd(3'h1, 1'b1, `TAG_SIMPLE, 8'h31, 1'b1, `RSP_QFULL);
    cmd(3'h1, 1'b0, `TAG_SIMPLE, 8'h00, 1'b1, `RSP_ACCEPT);
    // initiator 2 also waits untagged; only the owner may be dispatched
    n = 0;
    while (ev !== 1'b1 && n < 100) begin
      @(posedge CLK);
      #1;
      n = n + 1;
    end
    chk({eu, ei}, 4'h9, "exec_owner");
    evt(3'h4, 3'h4);
    evt(3'h2, 3'h1);
    chk(eca, 1, "eca");
    evt(3'h4, 3'h1);
    chk(eca, 0, "eca");
    @(posedge CLK);
    aflag <= 1'b1;
    asent <= 1'b1;
    ai <= 3'h6;
    evt(3'h1, 3'h0);
    chk({eca, eo}, 4'hE, "event_eca");
    evt(3'h3, 3'h0);
    chk(eca, 0, "eca");
    @(posedge CLK);
    aflag <= 1'b0;
    tdis <= 1'b1;
    cmd(3'h2, 1'b1, `TAG_SIMPLE, 8'h41, 1'b1, `RSP_ACCEPT);
    chk(rj, 1, "reject");
    @(posedge CLK);
    tdis <= 1'b0;
    qab <= 1'b1;
    sep <= 1'b1;
    slow <= 1'b1;
    cmd(3'h0, 1'b1, `TAG_SIMPLE, 8'h51, 1'b1, `RSP_ACCEPT);
    repeat (3) @(posedge CLK);
    cmd(3'h5, 1'b0, `TAG_SIMPLE, 8'h00, 1'b0, `RSP_BUSY);
    cmd(3'h3, 1'b1, `TAG_SIMPLE, 8'h52, 1'b1, `RSP_ACCEPT);
    evt(3'h0, 3'h2);
    @(posedge CLK);
    #1;
    chk(sus, 1, "suspended");
    evt(3'h2, 3'h2);
    n = 0;
    while (ua === 8'h00 && n < 4) begin
      @(posedge CLK);
      #1;
      n = n + 1;
    end
    chk(ua, 8'hFB, "ua_set");
    repeat (3) @(posedge CLK);
    chk(qc, 0, "qcount");
    chk(sus, 0, "suspended");
    report_and_stop;
  end
endmodule // target_queue_allegiance_manager_tb_top
